// >>> hw/slb_panel.sv
`timescale 1ns/100ps
`include "slb_defs.svh"

// Operation
// - ready led steady red while powered and still booting with no fault.
// - ready led blinks red on address conflict, address server failure or relay alarm.
// - ready led steady green once booted with no fault.
// - ready led blinks green while a locate request is active once booted with no fault.
// - ready led dark when power absent or power error flagged.
// - ethernet link led orange on low-speed link.
// - ethernet link led green on high-speed link.
// - ethernet link led off when the port has no link.
// - serial activity led orange while receiving and not sending.
// - serial activity led green while sending.
// - serial activity led off when neither sending nor receiving.
// - fiber led steady orange when link up and idle.
// - fiber led blinks orange when link up with traffic.
// - one power led per input, lit whenever that input has supply.
// - on becoming ready, two 100 ms tones with 100 ms gap.
// - while locating, 100 ms tone then 900 ms silence, repeated.
module slb_panel #(
   parameter int unsigned BLINK_HALF_CYC = `SLB_BLINK_HALF_CYC,
   parameter int unsigned TONE_CYC = `SLB_TONE_CYC,
   parameter int unsigned GAP_CYC = `SLB_GAP_CYC,
   parameter int unsigned LOC_GAP_CYC = `SLB_LOC_GAP_CYC,
   parameter int unsigned STRETCH_CYC = `SLB_STRETCH_CYC
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic [`SLB_PWR_INPUTS-1:0] power_present_i,
   input wire logic power_error_i,
   input wire logic booting_i,
   input wire logic ip_conflict_i,
   input wire logic addr_server_fail_i,
   input wire logic relay_alarm_i,
   input wire logic locate_i,
   input wire logic [`SLB_ETH_PORTS-1:0] eth_link_i,
   input wire logic [`SLB_ETH_PORTS-1:0] eth_high_speed_i,
   input wire logic [`SLB_SER_PORTS-1:0] ser_rx_i,
   input wire logic [`SLB_SER_PORTS-1:0] ser_tx_i,
   input wire logic fiber_fitted_i,
   input wire logic fiber_link_i,
   input wire logic fiber_traffic_i,
   output slb_pkg::slb_led_t ready_led_o,
   output slb_pkg::slb_led_t ethernet_link_led_a_o,
   output slb_pkg::slb_led_t ethernet_link_led_b_o,
   output slb_pkg::slb_led_t [`SLB_SER_PORTS-1:0] serial_activity_led_o,
   output slb_pkg::slb_led_t fiber_link_led_o,
   output logic power_input_a_led_o,
   output logic power_input_b_led_o,
   output logic beeper_o
);
   import slb_pkg::*;

   localparam slb_led_t LED_OFF = 2'h0;
   localparam slb_led_t LED_GREEN = 2'h1;
   localparam slb_led_t LED_RED = 2'h2;
   localparam slb_led_t LED_ORANGE = 2'h3;

   // ==========================================================
   // state
   typedef struct packed {
      // blink divider
      logic [24:0] blink_cnt;
      logic blink_tick;
      logic blink_phase;
      // beeper sequencer
      slb_beep_t beep;
      logic [26:0] beep_cnt;
      logic [1:0] tones_left;
      logic was_ready;
      // registered outputs
      slb_led_t ready_led;
      slb_led_t eth_a;
      slb_led_t eth_b;
      slb_led_t [`SLB_SER_PORTS-1:0] ser_led;
      slb_led_t fiber;
      logic pwr_a;
      logic pwr_b;
      logic beeper;
   } slb_panel_state_t;

   slb_panel_state_t st, next_st;

   logic [`SLB_SER_PORTS-1:0] rx_held;
   logic [`SLB_SER_PORTS-1:0] tx_held;

   // ==========================================================
   // activity stretchers
   for (genvar p = 0; p < `SLB_SER_PORTS; p++) begin : g_ser
      slb_stretch #(
         .HOLD_CYC(STRETCH_CYC)
      ) u_rx (
         .clk_i(clk_i),
         .sys_rst_i(sys_rst_i),
         .pulse_i(ser_rx_i[p]),
         .active_o(rx_held[p])
      );
      slb_stretch #(
         .HOLD_CYC(STRETCH_CYC)
      ) u_tx (
         .clk_i(clk_i),
         .sys_rst_i(sys_rst_i),
         .pulse_i(ser_tx_i[p]),
         .active_o(tx_held[p])
      );
   end

   function automatic slb_led_t link_colour(input logic link, input logic high);
      if (!link) begin
         return LED_OFF;
      end else if (high) begin
         return LED_GREEN;
      end else begin
         return LED_ORANGE;
      end
   endfunction

   logic powered;
   logic fault;
   logic ready_now;
   assign powered = (|power_present_i) && !power_error_i;
   assign fault = ip_conflict_i || addr_server_fail_i || relay_alarm_i;
   assign ready_now = powered && !booting_i;

   logic ready_rise;
   // startup pair fires once per power-up or end of boot
   assign ready_rise = ready_now && !st.was_ready;

   // ==========================================================
   // colour decoders
   // the blink phase runs free, so a brief fault may land in the lit half or in the dark half
   function automatic slb_led_t blink_colour(input logic phase, input slb_led_t colour);
      if (phase) begin
         return colour;
      end else begin
         return LED_OFF;
      end
   endfunction

   // fault checked before locate so an alarm is never masked by a search
   function automatic slb_led_t ready_colour(
      input logic pwr,
      input logic flt,
      input logic boot,
      input logic loc,
      input logic phase
   );
      if (!pwr) begin
         return LED_OFF;
      end else if (flt) begin
         return blink_colour(phase, LED_RED);
      end else if (boot) begin
         return LED_RED;
      end else if (loc) begin
         return blink_colour(phase, LED_GREEN);
      end else begin
         return LED_GREEN;
      end
   endfunction

   // tx shown green when both directions active
   function automatic slb_led_t serial_colour(input logic tx, input logic rx);
      if (tx) begin
         return LED_GREEN;
      end else if (rx) begin
         return LED_ORANGE;
      end else begin
         return LED_OFF;
      end
   endfunction

   // a unit without the fiber option keeps this led dark whatever the inputs say
   function automatic slb_led_t fiber_colour(
      input logic fitted,
      input logic link,
      input logic traffic,
      input logic phase
   );
      if (!fitted || !link) begin
         return LED_OFF;
      end else if (traffic) begin
         return blink_colour(phase, LED_ORANGE);
      end else begin
         return LED_ORANGE;
      end
   endfunction

   // ==========================================================
   // counter helpers
   function automatic logic [26:0] load_count(input int unsigned cyc);
      return 27'(cyc - 1);
   endfunction

   function automatic logic [26:0] count_down(input logic [26:0] cnt);
      return cnt - 27'h0000001;
   endfunction

   // ==========================================================
   // next state
   always_comb begin
      next_st = st;
      // ======================================================
      // blink divider
      // one-cycle tick; the phase moves only on that tick
      next_st.blink_tick = 1'b0;
      if (st.blink_cnt == 25'(BLINK_HALF_CYC - 1)) begin
         next_st.blink_cnt = '0;
         next_st.blink_tick = 1'b1;
      end else begin
         next_st.blink_cnt = st.blink_cnt + 25'h0000001;
      end
      if (st.blink_tick) begin
         next_st.blink_phase = !st.blink_phase;
      end

      // ======================================================
      // indicator colours
      next_st.ready_led = ready_colour(powered, fault, booting_i, locate_i, st.blink_phase);

      next_st.eth_a = link_colour(eth_link_i[0], eth_high_speed_i[0]);
      next_st.eth_b = link_colour(eth_link_i[1], eth_high_speed_i[1]);

      for (int i = 0; i < `SLB_SER_PORTS; i++) begin
         next_st.ser_led[i] = serial_colour(tx_held[i], rx_held[i]);
      end

      next_st.fiber = fiber_colour(fiber_fitted_i, fiber_link_i, fiber_traffic_i, st.blink_phase);

      next_st.pwr_a = power_present_i[0];
      next_st.pwr_b = power_present_i[1];

      // ======================================================
      // beeper sequencer
      next_st.was_ready = ready_now;
      unique case (st.beep)
         SLB_BP_IDLE: begin
            next_st.beeper = 1'b0;
            if (ready_rise) begin
               next_st.beep = SLB_BP_TONE;
               next_st.beep_cnt = load_count(TONE_CYC);
               next_st.tones_left = 2'(`SLB_STARTUP_TONES - 1);
               next_st.beeper = 1'b1;
            end else if (ready_now && locate_i) begin
               next_st.beep = SLB_BP_LOC_TONE;
               next_st.beep_cnt = load_count(TONE_CYC);
               next_st.beeper = 1'b1;
            end
         end
         SLB_BP_TONE: begin
            if (st.beep_cnt != '0) begin
               next_st.beep_cnt = count_down(st.beep_cnt);
            end else if (st.tones_left != 2'h0) begin
               next_st.beep = SLB_BP_GAP;
               next_st.beep_cnt = load_count(GAP_CYC);
               next_st.beeper = 1'b0;
            end else begin
               next_st.beep = SLB_BP_DONE;
               next_st.beeper = 1'b0;
            end
         end
         SLB_BP_GAP: begin
            if (st.beep_cnt != '0) begin
               next_st.beep_cnt = count_down(st.beep_cnt);
            end else begin
               next_st.beep = SLB_BP_TONE;
               next_st.beep_cnt = load_count(TONE_CYC);
               next_st.tones_left = st.tones_left - 2'h1;
               next_st.beeper = 1'b1;
            end
         end
         // losing power or re-entering boot also ends a locate cycle
         SLB_BP_LOC_TONE: begin
            if (!locate_i || !ready_now) begin
               next_st.beep = SLB_BP_IDLE;
               next_st.beeper = 1'b0;
            end else if (st.beep_cnt != '0) begin
               next_st.beep_cnt = count_down(st.beep_cnt);
            end else begin
               next_st.beep = SLB_BP_LOC_GAP;
               next_st.beep_cnt = load_count(LOC_GAP_CYC);
               next_st.beeper = 1'b0;
            end
         end
         SLB_BP_LOC_GAP: begin
            if (!locate_i || !ready_now) begin
               next_st.beep = SLB_BP_IDLE;
            end else if (st.beep_cnt != '0) begin
               next_st.beep_cnt = count_down(st.beep_cnt);
            end else begin
               next_st.beep = SLB_BP_LOC_TONE;
               next_st.beep_cnt = load_count(TONE_CYC);
               next_st.beeper = 1'b1;
            end
         end
         SLB_BP_DONE: begin
            // lets locate start once the startup pair is over
            next_st.beep = SLB_BP_IDLE;
            next_st.beeper = 1'b0;
         end
         default: begin
            next_st.beep = SLB_BP_IDLE;
            next_st.beeper = 1'b0;
         end
      endcase
   end

   // ==========================================================
   // state register
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         // every output dark and silent while reset is held
         st.blink_cnt <= '0;
         st.blink_tick <= 1'b0;
         st.blink_phase <= 1'b0;
         st.beep <= SLB_BP_IDLE;
         st.beep_cnt <= '0;
         st.tones_left <= 2'h0;
         st.was_ready <= 1'b0;
         st.ready_led <= LED_OFF;
         st.eth_a <= LED_OFF;
         st.eth_b <= LED_OFF;
         st.ser_led <= '0;
         st.fiber <= LED_OFF;
         st.pwr_a <= 1'b0;
         st.pwr_b <= 1'b0;
         st.beeper <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   // ==========================================================
   // outputs, straight from the state register
   assign ready_led_o = st.ready_led;
   assign ethernet_link_led_a_o = st.eth_a;
   assign ethernet_link_led_b_o = st.eth_b;
   assign serial_activity_led_o = st.ser_led;
   assign fiber_link_led_o = st.fiber;
   assign power_input_a_led_o = st.pwr_a;
   assign power_input_b_led_o = st.pwr_b;
   assign beeper_o = st.beeper;
endmodule // slb_panel

// >>> shared/slb_defs.svh
`ifndef SLB_DEFS_SVH
`define SLB_DEFS_SVH

`define SLB_CLK_HZ 50000000
`define SLB_BLINK_HALF_MS 250
`define SLB_BLINK_HALF_CYC ((`SLB_CLK_HZ / 1000) * `SLB_BLINK_HALF_MS)
`define SLB_TONE_MS 100
`define SLB_TONE_CYC ((`SLB_CLK_HZ / 1000) * `SLB_TONE_MS)
`define SLB_GAP_MS 100
`define SLB_GAP_CYC ((`SLB_CLK_HZ / 1000) * `SLB_GAP_MS)
`define SLB_LOC_GAP_MS 900
`define SLB_LOC_GAP_CYC ((`SLB_CLK_HZ / 1000) * `SLB_LOC_GAP_MS)
`define SLB_STRETCH_MS 20
`define SLB_STRETCH_CYC ((`SLB_CLK_HZ / 1000) * `SLB_STRETCH_MS)
`define SLB_STARTUP_TONES 2
`define SLB_SER_PORTS 4
`define SLB_ETH_PORTS 2
`define SLB_PWR_INPUTS 2

`endif

// >>> shared/slb_pkg.sv
package slb_pkg;
   // bicolour led drive: bit1 red, bit0 green, both = orange
   typedef logic [1:0] slb_led_t;
   typedef enum logic [5:0] {
      SLB_BP_IDLE = 6'h01,
      SLB_BP_TONE = 6'h02,
      SLB_BP_GAP = 6'h04,
      SLB_BP_LOC_TONE = 6'h08,
      SLB_BP_LOC_GAP = 6'h10,
      SLB_BP_DONE = 6'h20
   } slb_beep_t;
endpackage

// >>> hw/slb_stretch.sv
`timescale 1ns/100ps
`include "slb_defs.svh"

// holds a level high for at least a minimum time after each pulse
module slb_stretch #(
   parameter int unsigned HOLD_CYC = `SLB_STRETCH_CYC
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic pulse_i,
   output logic active_o
);
   typedef struct packed {
      logic [23:0] cnt;
      logic active;
   } slb_str_state_t;

   slb_str_state_t st, next_st;

   always_comb begin
      next_st = st;
      if (pulse_i) begin
         next_st.cnt = 24'(HOLD_CYC - 1);
         next_st.active = 1'b1;
      end else if (st.cnt != 24'h000000) begin
         next_st.cnt = st.cnt - 24'h000001;
      end else begin
         next_st.active = 1'b0;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign active_o = st.active;
endmodule // slb_stretch

// >>> bench/slb_panel_properties.sv
`timescale 1ns/100ps
`include "slb_defs.svh"
// ==========
// panel checker
module slb_panel_props #(
   parameter int unsigned TONE_CYC = 10
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic [`SLB_PWR_INPUTS-1:0] power_present_i,
   input wire logic power_error_i,
   input wire logic booting_i,
   input wire logic ip_conflict_i,
   input wire logic addr_server_fail_i,
   input wire logic relay_alarm_i,
   input wire logic locate_i,
   input wire logic [`SLB_ETH_PORTS-1:0] eth_link_i,
   input wire logic [`SLB_ETH_PORTS-1:0] eth_high_speed_i,
   input wire logic [`SLB_SER_PORTS-1:0] ser_rx_i,
   input wire logic [`SLB_SER_PORTS-1:0] ser_tx_i,
   input wire slb_pkg::slb_led_t ready_led_o,
   input wire slb_pkg::slb_led_t ethernet_link_led_a_o,
   input wire slb_pkg::slb_led_t [`SLB_SER_PORTS-1:0] serial_activity_led_o,
   input wire logic power_input_a_led_o,
   input wire logic beeper_o
);
   import slb_pkg::*;
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   logic pwr;
   logic flt;
   int unsigned on_cnt;
   assign pwr = (|power_present_i) && !power_error_i;
   assign flt = ip_conflict_i || addr_server_fail_i || relay_alarm_i;
   // length of the current tone so far
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         on_cnt <= 0;
      end else begin
         on_cnt <= beeper_o ? on_cnt + 1 : 0;
      end
   end
   AST_PWR_A: assert property (1 |=> power_input_a_led_o == $past(power_present_i[0]))
      else $error("power a led wrong");
   AST_DARK: assert property (!pwr |=> ready_led_o == 2'h0)
      else $error("ready led lit without power");
   AST_BOOT_RED: assert property (pwr && booting_i && !flt |=> ready_led_o == 2'h2)
      else $error("ready led not red while booting");
   AST_GREEN: assert property (pwr && !booting_i && !flt && !locate_i |=> ready_led_o == 2'h1)
      else $error("ready led not green");
   AST_FAULT: assert property (pwr && flt |=> ready_led_o inside {2'h0, 2'h2})
      else $error("fault not shown red");
   AST_LOCATE: assert property (pwr && !booting_i && !flt && locate_i |=> ready_led_o inside {2'h0, 2'h1})
      else $error("locate not shown green");
   AST_ETH_A: assert property (1 |=> ethernet_link_led_a_o == (!$past(eth_link_i[0]) ? 2'h0 :
         ($past(eth_high_speed_i[0]) ? 2'h1 : 2'h3))) else $error("link led a wrong");
   AST_TX: assert property (ser_tx_i[0] |=> ##1 serial_activity_led_o[0] == 2'h1)
      else $error("send not green");
   AST_RX: assert property ((!ser_tx_i[0])[*5] ##1 (ser_rx_i[0] && !ser_tx_i[0])
      |=> ##1 serial_activity_led_o[0] == 2'h3) else $error("receive not orange");
   AST_IDLE: assert property ((!ser_tx_i[0] && !ser_rx_i[0])[*5] |=> ##1 serial_activity_led_o[0] == 2'h0)
      else $error("idle serial led lit");
   AST_TONE: assert property (on_cnt <= TONE_CYC)
      else $error("tone too long");
endmodule // slb_panel_props

bind slb_panel slb_panel_props #(.TONE_CYC(TONE_CYC)) u_props (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
   .power_present_i(power_present_i), .power_error_i(power_error_i), .booting_i(booting_i),
   .ip_conflict_i(ip_conflict_i), .addr_server_fail_i(addr_server_fail_i), .relay_alarm_i(relay_alarm_i),
   .locate_i(locate_i), .eth_link_i(eth_link_i), .eth_high_speed_i(eth_high_speed_i), .ser_rx_i(ser_rx_i),
   .ser_tx_i(ser_tx_i), .ready_led_o(ready_led_o), .ethernet_link_led_a_o(ethernet_link_led_a_o),
   .serial_activity_led_o(serial_activity_led_o), .power_input_a_led_o(power_input_a_led_o),
   .beeper_o(beeper_o));

// >>> bench/slb_front_panel.sv
`timescale 1ns/100ps
// ==========
// beeper side: times every tone and every silence
module slb_front_panel (
   input wire logic clk_i,
   input wire logic beeper_i,
   output int tones_o,
   output int on_len_o,
   output int off_len_o
);
   int run = 0;
   logic last = 1'b0;
   initial tones_o = 0;
   always @(posedge clk_i) begin
      if (beeper_i !== last) begin
         if (last) on_len_o = run;
         else off_len_o = run;
         if (beeper_i) tones_o++;
         run = 1;
      end else begin
         run++;
      end
      last = beeper_i;
   end
endmodule // slb_front_panel

// >>> bench/status_led_beeper_ctrl_test.sv
`timescale 1ns/100ps
`include "slb_defs.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_total++; $display("Error t=%0t got=%0h exp=%0h", $time, g, e); end end
module status_led_beeper_ctrl_test;
   import slb_pkg::*;
   typedef struct {int sel; logic [31:0] val; bit blink;} slb_note_t;
   localparam int BLINK = 4;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [1:0] pp = 2'h0, el = 2'h0, es = 2'h0;
   logic perr = 1'b0, boot = 1'b1, loc = 1'b0;
   logic [2:0] flt = 3'h0, fib = 3'h0;
   logic [3:0] rx = 4'h0, tx = 4'h0;
   slb_led_t rdy, ea, eb, fl;
   slb_led_t [3:0] sl;
   logic pa, pb, bp;
   int tones, onl, offl, p, seed, pend = 0, err_total = 0, samples_checked = 0;
   logic [2:0] seen;
   slb_note_t notes[$];
   slb_note_t n;
   slb_panel #(.BLINK_HALF_CYC(BLINK), .TONE_CYC(10), .GAP_CYC(10), .LOC_GAP_CYC(20), .STRETCH_CYC(3)) u_dut (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i), .power_present_i(pp), .power_error_i(perr), .booting_i(boot),
      .ip_conflict_i(flt[0]), .addr_server_fail_i(flt[1]), .relay_alarm_i(flt[2]), .locate_i(loc),
      .eth_link_i(el), .eth_high_speed_i(es), .ser_rx_i(rx), .ser_tx_i(tx), .fiber_fitted_i(fib[0]),
      .fiber_link_i(fib[1]), .fiber_traffic_i(fib[2]), .ready_led_o(rdy), .ethernet_link_led_a_o(ea),
      .ethernet_link_led_b_o(eb), .serial_activity_led_o(sl), .fiber_link_led_o(fl),
      .power_input_a_led_o(pa), .power_input_b_led_o(pb), .beeper_o(bp));
   slb_front_panel u_panel (.clk_i(clk_i), .beeper_i(bp), .tones_o(tones), .on_len_o(onl), .off_len_o(offl));
   initial begin
      forever #10 clk_i = ~clk_i;
   end
   function automatic logic [31:0] pick(int sel);
      case (sel)
         0: pick = rdy;
         1: pick = ea;
         2: pick = eb;
         3: pick = fl;
         4: pick = {pb, pa};
         9: pick = tones;
         10: pick = onl;
         11: pick = offl;
         12: pick = bp;
         default: pick = sl[sel-5];
      endcase
   endfunction
   task automatic step(int k);
      repeat (k) @(negedge clk_i);
   endtask
   task automatic want(int sel, logic [31:0] val, bit blink = 1'b0);
      notes.push_back('{sel, val, blink});
      pend++;
      wait (pend == 0);
   endtask
   // ==========
   // monitor: a blink must show both off and the colour, nothing else
   always @(negedge clk_i) begin
      if (notes.size() > 0) begin
         n = notes.pop_front();
         seen = 3'h0;
         if (n.blink) begin
            repeat (2 * BLINK + 2) begin
               seen |= (pick(n.sel) === 32'h0) ? 3'h1 : (pick(n.sel) === n.val) ? 3'h2 : 3'h4;
               @(negedge clk_i);
            end
            `CHK(seen, 3'h3)
         end else begin
            `CHK(pick(n.sel), n.val)
         end
         pend--;
      end
   end
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // ==========
   // watchdog, run needs well under 1000 cycles
   initial begin
      #(20 * 4000);
      err_total++;
      finish_test();
   end
   // ==========
   // stimulus, changed on falling edges only
   initial begin
      seed = 24;
      step(12);
      sys_rst_i = 1'b0;
      for (int i = 0; i < 4; i++) begin
         pp = i[1:0];
         step(3);
         want(4, i);
         want(0, (i == 0) ? 0 : 2);
      end
      perr = 1'b1;
      step(3);
      want(0, 0);
      perr = 1'b0;
      $display("test power done");
      for (int i = 0; i < 3; i++) begin
         flt = 3'h1 << i;
         loc = 1'b1;
         step(3);
         want(0, 2, 1'b1);
      end
      flt = 3'h0;
      loc = 1'b0;
      boot = 1'b0;
      step(3);
      want(0, 1);
      step(50);
      want(9, 2);
      want(10, 10);
      want(11, 10);
      $display("test startup done");
      loc = 1'b1;
      step(3);
      want(0, 1, 1'b1);
      step(70);
      want(10, 10);
      want(11, 20);
      loc = 1'b0;
      step(3);
      want(12, 0);
      $display("test locate done");
      for (int i = 0; i < 16; i++) begin
         {el, es} = i[3:0];
         step(3);
         want(1, el[0] ? (es[0] ? 1 : 3) : 0);
         want(2, el[1] ? (es[1] ? 1 : 3) : 0);
      end
      $display("test ethernet done");
      for (int i = 0; i < 12; i++) begin
         p = $random(seed) & 3;
         tx[p] = (i % 3 != 1);
         rx[p] = (i % 3 != 0);
         step(1);
         tx = 4'h0;
         rx = 4'h0;
         step(1);
         want(5 + p, (i % 3 == 1) ? 3 : 1);
         step(8);
         want(5 + p, 0);
      end
      $display("test serial done");
      fib = 3'b011;
      step(3);
      want(3, 3);
      fib = 3'b111;
      step(3);
      want(3, 3, 1'b1);
      fib = 3'b110;
      step(3);
      want(3, 0);
      $display("test fiber done");
      finish_test();
   end
endmodule // status_led_beeper_ctrl_test
